// file: design/mmr_slave.sv
// mmr_slave: serial RTU slave serving flow, consumption and pressure.
// assumes measurement words and configuration inputs are synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
`include "mmr_defs.svh"
module mmr_slave #(
    parameter logic [15:0] BAUD_DEFAULT = 16'(`MMR_BAUD_DEFAULT)
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_rx,
    input  wire logic [7:0]  i_station_addr,
    input  wire logic [15:0] i_baud_div,
    input  wire logic [31:0] i_flow_value,
    input  wire logic [31:0] i_consumption_total,
    input  wire logic [31:0] i_pressure_value,
    output logic             o_tx,
    output logic             o_tx_en,
    output logic             o_frame_ok
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MMR_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_step

    // ----------------------------------------------------------------
    // input sync and receiver
    // ----------------------------------------------------------------
    logic [2:0]  rx_sync_reg, rx_sync_next;
    logic [15:0] div;
    // a zero divider would stall the link; fall back to default rate
    assign div = (i_baud_div == 16'h0000) ? 16'(`MMR_CLK_HZ / BAUD_DEFAULT) : i_baud_div;

    logic        rx_line;
    assign rx_line = rx_sync_reg[2];

    logic [15:0] rcnt_reg, rcnt_next;
    logic [3:0]  rbit_reg, rbit_next;
    logic [7:0]  rsh_reg,  rsh_next;
    logic        rbusy_reg, rbusy_next;
    logic        rbyte;
    logic [23:0] idle_reg, idle_next;
    logic [23:0] gap_cycles;
    assign gap_cycles = 24'(div) * 24'(`MMR_GAP_CHARS * `MMR_BITS_PER_CHAR);

    always_comb begin
        rcnt_next  = rcnt_reg;
        rbit_next  = rbit_reg;
        rsh_next   = rsh_reg;
        rbusy_next = rbusy_reg;
        rbyte      = 1'b0;
        rx_sync_next = {rx_sync_reg[1:0], i_rx};
        if (!rbusy_reg) begin
            if (rx_sync_reg[2] == 1'b0 && rx_sync_reg[1] == 1'b0) begin
                rbusy_next = 1'b1;
                rcnt_next  = {1'b0, div[15:1]};
                rbit_next  = 4'h0;
            end
        end else if (rcnt_reg >= div - 16'h0001) begin
            rcnt_next = 16'h0000;
            if (rbit_reg == 4'h0) begin
                if (rx_line) rbusy_next = 1'b0;
                rbit_next = 4'h1;
            end else if (rbit_reg == 4'h9) begin
                rbusy_next = 1'b0;
                rbyte      = rx_line;
            end else begin
                rsh_next  = {rx_line, rsh_reg[7:1]};
                rbit_next = rbit_reg + 4'h1;
            end
        end else begin
            rcnt_next = rcnt_reg + 16'h0001;
        end
        if (rbusy_reg || !rx_line) idle_next = 24'h000000;
        else if (idle_reg != 24'hFFFFFF) idle_next = idle_reg + 24'h000001;
        else idle_next = idle_reg;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            // idle level, so leaving reset shows no false start bit
            rx_sync_reg <= 3'h7;
            rcnt_reg    <= 16'h0000;
            rbit_reg    <= 4'h0;
            rsh_reg     <= 8'h00;
            rbusy_reg   <= 1'b0;
            idle_reg    <= 24'h000000;
        end else begin
            rx_sync_reg <= rx_sync_next;
            rcnt_reg    <= rcnt_next;
            rbit_reg    <= rbit_next;
            rsh_reg     <= rsh_next;
            rbusy_reg   <= rbusy_next;
            idle_reg    <= idle_next;
        end
    end

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    // two registers per value, high word first; unmapped registers read zero
    function automatic logic [15:0] reg_word(input logic [15:0] a, input logic [95:0] s);
        logic [31:0] v;
        v = 32'h00000000;
        if ((a & 16'hFFFE) == `MMR_REG_FLOW) begin
            v = s[95:64];
        end else if ((a & 16'hFFFE) == `MMR_REG_CONSUMPTION) begin
            v = s[63:32];
        end else if ((a & 16'hFFFE) == `MMR_REG_PRESSURE) begin
            v = s[31:0];
        end
        return a[0] ? v[15:0] : v[31:16];
    endfunction : reg_word

    // ----------------------------------------------------------------
    // frame logic
    // ----------------------------------------------------------------
    mmr_pkg::mmr_state_t state_reg, state_next;
    logic [7:0]  buf_reg [0:7];
    logic [7:0]  buf_next [0:7];
    logic [3:0]  rlen_reg,  rlen_next;
    logic [15:0] rcrc_reg,  rcrc_next;
    logic [15:0] start_reg, start_next;
    logic [3:0]  words_reg, words_next;
    logic [4:0]  tidx_reg,  tidx_next;
    logic [15:0] tcrc_reg,  tcrc_next;
    logic [95:0] snap_reg,  snap_next;
    logic        ok_reg,    ok_next;
    logic        tx_reg,    tx_next;
    logic        tx_en_reg, tx_en_next;
    logic        tx_line;
    logic        frame_good;
    logic [15:0] req_start, req_count;
    logic [4:0]  data_end,  reply_len, data_k;
    logic [15:0] word_now;
    logic [7:0]  tx_byte;
    mmr_tx_if    tx_if ();

    assign req_start  = {buf_reg[2], buf_reg[3]};
    assign req_count  = {buf_reg[4], buf_reg[5]};
    // a frame with its own crc appended folds to zero; address zero is never ours
    assign frame_good = (rlen_reg == 4'(`MMR_REQ_LEN)) && (rcrc_reg == 16'h0000)
                     && (buf_reg[0] == i_station_addr) && (i_station_addr != 8'h00)
                     && (buf_reg[1] == `MMR_FUNC_READ) && (req_count != 16'h0000)
                     && (req_count <= {8'h00, `MMR_MAX_REGS})
                     && (({1'b0, req_start} + {1'b0, req_count}) <= {1'b0, `MMR_REG_LIMIT});
    assign data_end    = 5'h03 + {words_reg, 1'b0};
    assign reply_len   = data_end + 5'h02;
    assign data_k      = tidx_reg - 5'h03;
    assign word_now    = reg_word(start_reg + {12'h000, data_k[4:1]}, snap_reg);
    assign tx_if.valid = (state_reg == mmr_pkg::MMR_RX_SEND) && (tidx_reg < reply_len);
    assign tx_if.data  = tx_byte;

    always_comb begin
        if (tidx_reg == 5'h00) begin
            tx_byte = buf_reg[0];
        end else if (tidx_reg == 5'h01) begin
            tx_byte = `MMR_FUNC_READ;
        end else if (tidx_reg == 5'h02) begin
            tx_byte = {3'h0, words_reg, 1'b0};
        end else if (tidx_reg < data_end) begin
            // no swap: register bytes leave high first, ABCD as held
            tx_byte = data_k[0] ? word_now[7:0] : word_now[15:8];
        end else if (tidx_reg == data_end) begin
            tx_byte = tcrc_reg[7:0];
        end else begin
            tx_byte = tcrc_reg[15:8];
        end
    end

    mmr_uart_tx u_tx (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_div  (div),
        .tx     (tx_if),
        .o_line (tx_line),
        .o_busy ()
    );

    always_comb begin
        state_next = state_reg;
        for (int i = 0; i < 8; i++) begin
            buf_next[i] = buf_reg[i];
        end
        rlen_next  = rlen_reg;
        rcrc_next  = rcrc_reg;
        start_next = start_reg;
        words_next = words_reg;
        tidx_next  = tidx_reg;
        tcrc_next  = tcrc_reg;
        snap_next  = snap_reg;
        ok_next    = 1'b0;
        tx_next    = tx_line;
        tx_en_next = (state_reg == mmr_pkg::MMR_RX_SEND);
        case (state_reg)
            mmr_pkg::MMR_RX_IDLE: begin
                if (rbyte) begin
                    buf_next[0] = rsh_reg;
                    rlen_next   = 4'h1;
                    rcrc_next   = crc_step(`MMR_CRC_INIT, rsh_reg);
                    state_next  = mmr_pkg::MMR_RX_FRAME;
                end
            end
            mmr_pkg::MMR_RX_FRAME: begin
                if (rbyte) begin
                    // keep counting past the buffer so overlong frames fail
                    if (rlen_reg < 4'h8) begin
                        buf_next[rlen_reg[2:0]] = rsh_reg;
                    end
                    if (rlen_reg != 4'h9) begin
                        rlen_next = rlen_reg + 4'h1;
                    end
                    rcrc_next = crc_step(rcrc_reg, rsh_reg);
                end
                if (idle_reg == gap_cycles) begin
                    state_next = mmr_pkg::MMR_RX_TURN;
                end
            end
            mmr_pkg::MMR_RX_TURN: begin
                if (frame_good) begin
                    state_next = mmr_pkg::MMR_RX_SEND;
                    start_next = req_start;
                    words_next = req_count[3:0];
                    tidx_next  = 5'h00;
                    tcrc_next  = `MMR_CRC_INIT;
                    // snapshot, so no value tears between its two registers
                    snap_next  = {i_flow_value, i_consumption_total, i_pressure_value};
                    ok_next    = 1'b1;
                end else begin
                    state_next = mmr_pkg::MMR_RX_IDLE;
                end
            end
            mmr_pkg::MMR_RX_SEND: begin
                if (tx_if.valid && tx_if.ready) begin
                    tidx_next = tidx_reg + 5'h01;
                    if (tidx_reg < data_end) begin
                        tcrc_next = crc_step(tcrc_reg, tx_byte);
                    end
                end
                if ((tidx_reg == reply_len) && tx_if.ready) begin
                    state_next = mmr_pkg::MMR_RX_IDLE;
                end
            end
            default: begin
                state_next = mmr_pkg::MMR_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= mmr_pkg::MMR_RX_IDLE;
            for (int i = 0; i < 8; i++) begin
                buf_reg[i] <= 8'h00;
            end
            rlen_reg  <= 4'h0;
            rcrc_reg  <= `MMR_CRC_INIT;
            start_reg <= 16'h0000;
            words_reg <= 4'h0;
            tidx_reg  <= 5'h00;
            tcrc_reg  <= `MMR_CRC_INIT;
            snap_reg  <= 96'h0;
            ok_reg    <= 1'b0;
            tx_reg    <= 1'b1;
            tx_en_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            for (int i = 0; i < 8; i++) begin
                buf_reg[i] <= buf_next[i];
            end
            rlen_reg  <= rlen_next;
            rcrc_reg  <= rcrc_next;
            start_reg <= start_next;
            words_reg <= words_next;
            tidx_reg  <= tidx_next;
            tcrc_reg  <= tcrc_next;
            snap_reg  <= snap_next;
            ok_reg    <= ok_next;
            tx_reg    <= tx_next;
            tx_en_reg <= tx_en_next;
        end
    end

    assign o_tx       = tx_reg;
    assign o_tx_en    = tx_en_reg;
    assign o_frame_ok = ok_reg;

    gap_ends_frame_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (state_reg == mmr_pkg::MMR_RX_FRAME) && (idle_reg == gap_cycles)
        |=> (state_reg == mmr_pkg::MMR_RX_TURN)) else $error("idle gap did not end the frame");
    reply_starts_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (state_reg == mmr_pkg::MMR_RX_TURN) && frame_good
        |=> (state_reg == mmr_pkg::MMR_RX_SEND) && tx_if.valid) else $error("reply was delayed");
    bad_frame_quiet_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (state_reg == mmr_pkg::MMR_RX_TURN) && !frame_good
        |=> (state_reg == mmr_pkg::MMR_RX_IDLE) && !ok_reg) else $error("refused frame answered");
    own_station_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        ok_reg |-> $past(buf_reg[0] == i_station_addr)) else $error("foreign address accepted");
    func_code_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        (state_reg == mmr_pkg::MMR_RX_SEND) && (tidx_reg == 5'h01)
        |-> (tx_if.data == `MMR_FUNC_READ)) else $error("reply function code wrong");
    line_idle_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !tx_en_reg |-> tx_reg) else $error("line not idle high while released");
endmodule : mmr_slave
`default_nettype wire

// file: design/mmr_defs.svh
// mmr_defs.svh: offsets, field positions, reset values and timing counts
// of the measurement readout slave; definitions only.
`ifndef MMR_DEFS_SVH
`define MMR_DEFS_SVH

`define MMR_CLK_HZ          25000000
`define MMR_BAUD_DEFAULT    19200
`define MMR_BAUD_DIV(b)     (`MMR_CLK_HZ / (b))
`define MMR_GAP_CHARS       7
`define MMR_BITS_PER_CHAR   10
`define MMR_FUNC_READ       8'h03
`define MMR_REG_PRESSURE    16'h0002
`define MMR_REG_FLOW        16'h0006
`define MMR_REG_CONSUMPTION 16'h0008
`define MMR_REG_LIMIT       16'h000A
`define MMR_CRC_INIT        16'hFFFF
`define MMR_CRC_POLY        16'hA001
`define MMR_MAX_REGS        8'h0A
`define MMR_REQ_LEN         8

`endif

// file: design/mmr_pkg.sv
// mmr_pkg: types used by the readout slave's frame logic.
// assumes mmr_defs.svh is compiled alongside.
package mmr_pkg;
    typedef enum logic [3:0] {
        MMR_RX_IDLE  = 4'b0001,
        MMR_RX_FRAME = 4'b0010,
        MMR_RX_TURN  = 4'b0100,
        MMR_RX_SEND  = 4'b1000
    } mmr_state_t;
endpackage : mmr_pkg

// file: design/mmr_tx_if.sv
// mmr_tx_if: byte handshake between frame logic and the transmitter.
// assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface mmr_tx_if;
    logic       valid;
    logic [7:0] data;
    logic       ready;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : mmr_tx_if
`default_nettype wire

// file: design/mmr_uart_tx.sv
// mmr_uart_tx: 8N1 character transmitter with runtime baud divider.
// assumes i_div is held stable while a character is in flight.
`timescale 1ns/1ps
`default_nettype none
`include "mmr_defs.svh"
module mmr_uart_tx (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic [15:0] i_div,
    mmr_tx_if.snk            tx,
    output logic             o_line,
    output logic             o_busy
);
    logic [15:0] cnt_reg,  cnt_next;
    logic [3:0]  bit_reg,  bit_next;
    logic [9:0]  sh_reg,   sh_next;
    logic        busy_reg, busy_next;

    always_comb begin
        cnt_next  = cnt_reg;
        bit_next  = bit_reg;
        sh_next   = sh_reg;
        busy_next = busy_reg;
        if (!busy_reg) begin
            if (tx.valid) begin
                // stop, data lsb first, start; 8N1
                sh_next   = {1'b1, tx.data, 1'b0};
                busy_next = 1'b1;
                cnt_next  = 16'h0000;
                bit_next  = 4'h0;
            end
        end else if (cnt_reg >= i_div - 16'h0001) begin
            cnt_next = 16'h0000;
            sh_next  = {1'b1, sh_reg[9:1]};
            if (bit_reg == 4'(`MMR_BITS_PER_CHAR - 1)) begin
                busy_next = 1'b0;
            end else begin
                bit_next = bit_reg + 4'h1;
            end
        end else begin
            cnt_next = cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg  <= 16'h0000;
            bit_reg  <= 4'h0;
            sh_reg   <= 10'h3FF;
            busy_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            bit_reg  <= bit_next;
            sh_reg   <= sh_next;
            busy_reg <= busy_next;
        end
    end

    assign tx.ready = !busy_reg;
    assign o_line   = busy_reg ? sh_reg[0] : 1'b1;
    assign o_busy   = busy_reg;
endmodule : mmr_uart_tx
`default_nettype wire

// file: testbench/mmr_master.sv
// mmr_master: serial master model, 8N1, bit time given in clocks.
// assumes the slave line is biased high while released.
`timescale 1ns/1ps
`default_nettype none
module mmr_master (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_div,
    input  wire logic        i_line,
    output logic             o_line
);
    initial o_line = 1'b1;
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 10; i++) begin
            #1 o_line = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
            repeat (i_div) @(posedge i_clk);
        end
    endtask : send
    // bounded wait stands in for the one-second reply limit
    task automatic recv(input int lim, output logic [7:0] b, output bit ok);
        ok = 1'b0;
        for (int n = 0; n < lim && !ok; n++) begin
            @(posedge i_clk);
            #1 ok = (i_line === 1'b0);
        end
        if (ok) begin
            repeat (i_div + i_div / 2) @(posedge i_clk);
            for (int i = 0; i < 8; i++) begin
                #1 b[i] = i_line;
                repeat (i_div) @(posedge i_clk);
            end
        end
    endtask : recv
endmodule : mmr_master
`default_nettype wire

// file: testbench/modbus_measurement_readout_test.sv
// modbus_measurement_readout_test: reads, refusals and live changes.
// assumes a fast divider so frames stay short in simulation.
`timescale 1ns/1ps
`default_nettype none
module modbus_measurement_readout_test;
    logic [15:0] div;
    logic        i_clk, i_rst, rx, tx, tx_en, line, frame_ok;
    logic [7:0]  st;
    logic [31:0] flow, cons, pres;
    int          n_mismatch, samples_checked, n_ok;
    assign line = tx_en ? tx : 1'b1;
    mmr_slave dut (.i_clk(i_clk), .i_rst(i_rst), .i_rx(rx), .i_station_addr(st),
        .i_baud_div(div), .i_flow_value(flow), .i_consumption_total(cons),
        .i_pressure_value(pres), .o_tx(tx), .o_tx_en(tx_en), .o_frame_ok(frame_ok));
    mmr_master m (.i_clk(i_clk), .i_div(div), .i_line(line), .o_line(rx));
    always @(negedge i_clk) begin
        if (frame_ok === 1'b1) n_ok++;
    end
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction : crc
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic req(input logic [7:0] a, input logic [15:0] r, input logic bad);
        logic [7:0]  q[$];
        logic [15:0] c;
        q = {a, 8'h03, r[15:8], r[7:0], 8'h00, 8'h02};
        c = crc(q) ^ {15'h0000, bad};
        q.push_back(c[7:0]);
        q.push_back(c[15:8]);
        repeat (70 * div) @(posedge i_clk);
        foreach (q[i]) m.send(q[i]);
    endtask : req
    task automatic rd(input logic [15:0] r, input logic [31:0] v);
        logic [7:0]  e[$];
        logic [7:0]  b;
        logic [15:0] c;
        logic        idle;
        bit          ok;
        int          ok0;
        ok0 = n_ok;
        req(st, r, 1'b0);
        idle = 1'b1;
        repeat (65 * div) begin
            @(posedge i_clk);
            idle &= line;
        end
        chk("gap", {7'h00, idle}, 8'h01);
        e = {st, 8'h03, 8'h04, v[31:24], v[23:16], v[15:8], v[7:0]};
        c = crc(e);
        e.push_back(c[7:0]);
        e.push_back(c[15:8]);
        foreach (e[i]) begin
            m.recv(30 * div, b, ok);
            chk("reply", b, e[i]);
        end
        chk("frame ok", 8'(n_ok - ok0), 8'h01);
    endtask : rd
    task automatic quiet(input logic [7:0] a, input logic bad);
        logic idle;
        int   ok0;
        ok0 = n_ok;
        req(a, 16'h0006, bad);
        idle = 1'b1;
        repeat (140 * div) begin
            @(posedge i_clk);
            idle &= line;
        end
        chk("silent", {7'h00, idle}, 8'h01);
        chk("frame ok", 8'(n_ok - ok0), 8'h00);
    endtask : quiet
    task automatic t_regs;
        rd(16'h0006, flow);
        rd(16'h0008, cons);
        rd(16'h0002, pres);
    endtask : t_regs
    task automatic t_refuse;
        quiet(st + 8'h01, 1'b0);
        quiet(st, 1'b1);
    endtask : t_refuse
    task automatic t_change;
        @(posedge i_clk);
        #1 st = 8'h05;
        div = 16'h0014;
        flow = 32'h42C50A11;
        rd(16'h0006, flow);
    endtask : t_change
    task automatic test_done;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    initial begin
        repeat (60000) @(posedge i_clk);
        n_mismatch++;
        test_done;
    end
    initial begin
        i_rst = 1'b1;
        st = 8'h2A;
        div = 16'h0010;
        flow = 32'h0A1142C5;
        cons = 32'h00012345;
        pres = 32'h3F8CCCCD;
        repeat (6) @(posedge i_clk);
        #1 i_rst = 1'b0;
        t_regs;
        t_refuse;
        t_change;
        test_done;
    end
endmodule : modbus_measurement_readout_test
`default_nettype wire
